// [logic/long_press_timer.sv]
// long press timer: fires once per press held for the setup time
`timescale 1ns/100ps
module long_press_timer
  import supervisor_pkg::*;
#(
  parameter logic [CNT_W-1:0] SETUP_CYC = LONG_PRESS_SETUP_CYC
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // press request and strobe
  press_if.timer   pif
);
  logic [CNT_W-1:0] cnt_q, cnt_d;      // cycles the press has lasted
  logic             armed_q, armed_d;  // may fire on this press
  logic             fire_q, fire_d;    // fire strobe register

  // next values of the timer
  always_comb begin
    fire_d = armed_q && pif.cond && (cnt_q == SETUP_CYC - CNT_W'(1));  // R4 R5 R6
    if (!pif.cond) begin
      cnt_d = CNT_RST;  // short closure forgotten R4
    end else if (cnt_q == SETUP_CYC - CNT_W'(1)) begin
      cnt_d = cnt_q;    // hold at the end
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
    if (!pif.cond) begin
      armed_d = 1'b1;   // released, next press may fire R11
    end else if (fire_d) begin
      armed_d = 1'b0;   // one pulse per press R11
    end else begin
      armed_d = armed_q;
    end
  end

  // timer registers
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q   <= CNT_RST;
      armed_q <= 1'b0;
      fire_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      armed_q <= armed_d;
      fire_q  <= fire_d;
    end
  end

  assign pif.fire = fire_q;

  // fire only after a press of the full setup length
  property p_fire_cause;
    @(posedge mclk_in) disable iff (!arst_n_in)
      pif.fire |-> ($past(cnt_q) == SETUP_CYC - CNT_W'(1)) && $past(pif.cond);
  endproperty
  a_fire_cause: assert property (p_fire_cause) else $error("fire without full press"); // R4

  // no second fire while the same press lasts
  property p_no_refire;
    @(posedge mclk_in) disable iff (!arst_n_in)
      (!armed_q && pif.cond) |=> !pif.fire;
  endproperty
  a_no_refire: assert property (p_no_refire) else $error("second fire on one press"); // R11

  // a fire strobe occurs
  cover property (@(posedge mclk_in) disable iff (!arst_n_in) pif.fire);
endmodule

// [logic/press_if.sv]
// long press request and fire strobe between sequencer and press timer
`timescale 1ns/100ps
interface press_if;
  logic cond;  // selected manual inputs all low
  logic fire;  // one-cycle strobe when the press has lasted long enough
  modport timer (input cond, output fire);
  modport ctrl  (output cond, input fire);
endinterface

// [logic/supervisor_pkg.sv]
// constants, timing counts and enumerations for the reset supervisor
package supervisor_pkg;
  // clock rate
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // counter width, enough for the long press count
  localparam int unsigned CNT_W = 27;
  // times as printed
  localparam int unsigned RECOVERY_HOLD_TIME_MS    = 210;
  localparam int unsigned MANUAL_PULSE_TIME_MS     = 210;
  localparam int unsigned LONG_PRESS_SETUP_TIME_MS = 6720;
  localparam int unsigned IMM_DELAY_NS             = 200;
  // derived cycle counts
  localparam logic [CNT_W-1:0] RECOVERY_HOLD_CYC =
    CNT_W'(RECOVERY_HOLD_TIME_MS * (CLK_HZ / 1000));
  localparam logic [CNT_W-1:0] MANUAL_PULSE_CYC =
    CNT_W'(MANUAL_PULSE_TIME_MS * (CLK_HZ / 1000));
  localparam logic [CNT_W-1:0] LONG_PRESS_SETUP_CYC =
    CNT_W'(LONG_PRESS_SETUP_TIME_MS * (CLK_HZ / 1000));
  localparam logic [1:0] IMM_FILTER_CYC = 2'(IMM_DELAY_NS / CLK_PERIOD_NS);
  // reset values
  localparam logic [CNT_W-1:0] CNT_RST = '0;
  localparam logic [1:0]       FLT_RST = 2'h0;
  // manual input arrangement
  typedef enum logic [1:0] {VAR_SINGLE, VAR_DUAL_LONG, VAR_LONG_IMM} variant_e;
  // reset sequencer states
  typedef enum logic [1:0] {S_IDLE, S_FAULT, S_TIMEOUT, S_PULSE} hold_e;
endpackage

// [logic/supervisor_reset_timing.sv]
// reset sequencer: supply faults, recovery hold and manual reset inputs
// How it works
// R1: any supply under threshold asserts reset
// R2: hold reset recovery time after recovery
// R3: long press completing while idle gives one timed reset pulse
// R4: short presses produce no reset
// R5: long press setup time measured from low
// R6: dual variant needs both inputs low together
// R7: immediate input variant resets without setup delay
// R8: reset output is active low, drive selectable
// R9: immediate input filters glitches, responds quickly
// R10: manual pulse lasts its own PULSE_CYC timeout, set apart from the recovery hold
// R11: one pulse per press until released
`timescale 1ns/100ps
module supervisor_reset_timing
  import supervisor_pkg::*;
#(
  parameter variant_e         VARIANT      = VAR_SINGLE,           // manual input arrangement
  parameter bit               HAS_ADJ      = 1'b0,                 // adjustable monitor fitted
  parameter bit               OPEN_DRAIN   = 1'b0,                 // output drive style
  parameter logic [CNT_W-1:0] RECOVERY_CYC = RECOVERY_HOLD_CYC,    // hold after recovery
  parameter logic [CNT_W-1:0] PULSE_CYC    = MANUAL_PULSE_CYC,     // manual pulse length
  parameter logic [CNT_W-1:0] SETUP_CYC    = LONG_PRESS_SETUP_CYC  // long press time
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic arst_n_in,
  // comparator results, high while under threshold
  input  wire logic vcc_under_in,
  input  wire logic adjustable_monitor_under_in,
  // manual push buttons, low while pressed
  input  wire logic long_press_input_a_n_in,
  input  wire logic second_press_input_n_in,
  // reset to the processor
  output wire logic rst_n_out,
  output wire logic rst_oe_out
);
  hold_e            state_q, state_d;  // sequencer state
  logic [CNT_W-1:0] cnt_q, cnt_d;      // timeout counter
  logic             rst_n_q, rst_n_d;  // registered reset level
  logic [1:0]       flt_q, flt_d;      // immediate input low-run counter
  logic             imm_act;           // immediate input accepted low
  logic             fault;             // any condition forcing reset
  press_if          pif ();            // long press link

  // long press condition per variant
  always_comb begin
    if (VARIANT == VAR_DUAL_LONG) begin
      pif.cond = !long_press_input_a_n_in && !second_press_input_n_in;  // R6
    end else begin
      pif.cond = !long_press_input_a_n_in;  // R5
    end
  end

  // long press timer
  long_press_timer #(
    .SETUP_CYC (SETUP_CYC)
  ) u_press (
    .mclk_in   (mclk_in),
    .arst_n_in (arst_n_in),
    .pif       (pif)
  );

  // immediate input glitch filter, next value
  always_comb begin
    if ((VARIANT == VAR_LONG_IMM) && !second_press_input_n_in) begin
      flt_d = (flt_q == IMM_FILTER_CYC) ? flt_q : flt_q + 2'h1;  // count low run R9
    end else begin
      flt_d = FLT_RST;  // high or not fitted
    end
    imm_act = (VARIANT == VAR_LONG_IMM) && !second_press_input_n_in
              && (flt_q >= IMM_FILTER_CYC - 2'h1);  // R7 R9
  end

  // filter register
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flt_q <= FLT_RST;
    end else begin
      flt_q <= flt_d;
    end
  end

  // sequencer next state
  always_comb begin
    fault   = vcc_under_in || (HAS_ADJ && adjustable_monitor_under_in) || imm_act;  // R1
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      S_IDLE: begin
        if (fault) begin
          state_d = S_FAULT;  // R1
        end else if (pif.fire) begin
          state_d = S_PULSE;  // one-shot manual pulse R3
          cnt_d   = CNT_RST;
        end
      end
      S_FAULT: begin
        if (!fault) begin
          state_d = S_TIMEOUT;  // all supplies back R2
          cnt_d   = CNT_RST;
        end
      end
      S_TIMEOUT: begin
        if (fault) begin
          state_d = S_FAULT;
        end else if (cnt_q == RECOVERY_CYC - CNT_W'(1)) begin
          state_d = S_IDLE;  // hold done R2
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      S_PULSE: begin
        if (fault) begin
          state_d = S_FAULT;
        end else if (cnt_q == PULSE_CYC - CNT_W'(1)) begin
          state_d = S_IDLE;  // pulse done R10
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
    endcase
    rst_n_d = (state_d == S_IDLE);  // low means reset R8
  end

  // sequencer registers, power-up starts with a recovery hold
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= S_TIMEOUT;
      cnt_q   <= CNT_RST;
      rst_n_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      rst_n_q <= rst_n_d;
    end
  end

  // output drive: open drain only enables while pulling low
  assign rst_n_out  = rst_n_q;                          // R8
  assign rst_oe_out = OPEN_DRAIN ? !rst_n_q : 1'b1;     // R8

  // supply fault asserts reset next cycle
  property p_vcc_fault;
    @(posedge mclk_in) disable iff (!arst_n_in) vcc_under_in |=> !rst_n_out;
  endproperty
  a_vcc_fault: assert property (p_vcc_fault) else $error("reset missed on supply fault"); // R1

  // adjustable monitor fault asserts reset
  property p_adj_fault;
    @(posedge mclk_in) disable iff (!arst_n_in)
      (HAS_ADJ && adjustable_monitor_under_in) |=> !rst_n_out;
  endproperty
  a_adj_fault: assert property (p_adj_fault) else $error("reset missed on adj fault"); // R1

  // release after recovery only at the full hold count
  property p_hold_release;
    @(posedge mclk_in) disable iff (!arst_n_in)
      ($rose(rst_n_out) && ($past(state_q) == S_TIMEOUT))
        |-> ($past(cnt_q) == RECOVERY_CYC - CNT_W'(1));
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold length wrong"); // R2

  // release never while a supply is still under threshold
  property p_release_clean;
    @(posedge mclk_in) disable iff (!arst_n_in)
      $rose(rst_n_out)
        |-> $past(!vcc_under_in) && $past(!(HAS_ADJ && adjustable_monitor_under_in));
  endproperty
  a_release_clean: assert property (p_release_clean) else $error("release during fault"); // R2

  // manual pulse length
  property p_pulse_len;
    @(posedge mclk_in) disable iff (!arst_n_in)
      ($rose(rst_n_out) && ($past(state_q) == S_PULSE))
        |-> ($past(cnt_q) == PULSE_CYC - CNT_W'(1));
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("manual pulse length wrong"); // R10

  // fire while idle starts a pulse
  property p_fire_reset;
    @(posedge mclk_in) disable iff (!arst_n_in)
      (pif.fire && (state_q == S_IDLE)) |=> !rst_n_out ##1 !rst_n_out;
  endproperty
  a_fire_reset: assert property (p_fire_reset) else $error("long press gave no reset"); // R3

  // dual variant fires only with both inputs low
  property p_dual_both;
    @(posedge mclk_in) disable iff (!arst_n_in)
      (pif.fire && (VARIANT == VAR_DUAL_LONG))
        |-> $past(!long_press_input_a_n_in) && $past(!second_press_input_n_in);
  endproperty
  a_dual_both: assert property (p_dual_both) else $error("dual fire with one input"); // R6

  // immediate input held two cycles resets at once
  property p_imm_fast;
    @(posedge mclk_in) disable iff (!arst_n_in)
      ((VARIANT == VAR_LONG_IMM) && !second_press_input_n_in [*2]) |=> !rst_n_out;
  endproperty
  a_imm_fast: assert property (p_imm_fast) else $error("immediate input too slow"); // R7

  // single-cycle glitch on immediate input is rejected
  property p_imm_glitch;
    @(posedge mclk_in) disable iff (!arst_n_in)
      ((state_q == S_IDLE) && !vcc_under_in && !(HAS_ADJ && adjustable_monitor_under_in)
       && !pif.fire && !second_press_input_n_in && (flt_q == FLT_RST)) |=> rst_n_out;
  endproperty
  a_imm_glitch: assert property (p_imm_glitch) else $error("glitch caused reset"); // R9

  // open drain enable follows reset level
  property p_drive;
    @(posedge mclk_in) disable iff (!arst_n_in)
      rst_oe_out == (OPEN_DRAIN ? !rst_n_out : 1'b1);
  endproperty
  a_drive: assert property (p_drive) else $error("output enable wrong"); // R8

  // main scenarios
  cover property (@(posedge mclk_in) disable iff (!arst_n_in)
    (state_q == S_TIMEOUT) ##1 (state_q == S_IDLE));
  cover property (@(posedge mclk_in) disable iff (!arst_n_in)
    (state_q == S_PULSE) ##1 (state_q == S_IDLE));
  cover property (@(posedge mclk_in) disable iff (!arst_n_in)
    (state_q == S_IDLE) ##1 (state_q == S_FAULT));
endmodule

// [testbench/proc_partner.sv]
// processor and push button model on the far side of the reset sequencer
`timescale 1ns/100ps
module proc_partner (
  // reset pin from the sequencer
  input  wire logic rst_n_in,
  input  wire logic rst_oe_in,
  // button requests from the bench, high while pressed
  input  wire logic press_a_in,
  input  wire logic press_b_in,
  // resolved reset line and button contacts
  output wire logic rst_line_out,
  output wire logic btn_a_n_out,
  output wire logic btn_b_n_out
);
  // pull-up holds the line high whenever the driver is off
  assign rst_line_out = rst_oe_in ? rst_n_in : 1'b1;
  // closed contact pulls low, open contact rests at its pull-up
  assign btn_a_n_out  = !press_a_in;
  assign btn_b_n_out  = !press_b_in;
endmodule

// [testbench/testbench.sv]
// self-checking bench for the reset sequencer
`timescale 1ns/100ps
module testbench;
  import supervisor_pkg::*;
  typedef struct {int lo; int tol;} exp_s;
  localparam int REC = 10;         // shortened recovery hold
  localparam int PUL = 8;          // shortened manual pulse
  localparam int SET = 40;         // shortened long press time
  logic        mclk_in   = 1'b0;   // bench clock
  logic        arst_n_in = 1'b0;   // async reset
  logic        vcc_under = 1'b0;   // supply comparator
  logic        adj_under = 1'b0;   // adjustable comparator
  logic        press_a   = 1'b0;   // long press button held
  logic        press_b   = 1'b0;   // immediate button held
  logic        btn_a_n;            // contacts seen by the block
  logic        btn_b_n;
  logic        rst_n_out;          // block outputs
  logic        rst_oe_out;
  logic        rst_line;           // resolved reset wire
  logic        prev_line = 1'b0;   // line at the previous edge
  bit          armed     = 1'b0;   // a low period is being timed
  int          width     = 0;      // cycles low so far
  int          err_count = 0;
  int          n_checks  = 0;
  int          cycles    = 0;
  int unsigned len;                // random lengths
  exp_s        exp_q[$];           // expected low widths
  exp_s        e;
  logic        rst_n_dual;         // dual variant outputs
  logic        rst_oe_dual;
  logic        line_dual;          // its resolved reset wire
  logic        prev_dual  = 1'b0;  // its line at the previous edge
  bit          armed_dual = 1'b0;  // its low period is being timed
  int          width_dual = 0;     // its cycles low so far
  exp_s        dual_q[$];          // expected low widths, dual variant
  exp_s        e_dual;

  // clock, 100 ns period
  always #50 mclk_in = !mclk_in;

  supervisor_reset_timing #(
    .VARIANT(VAR_LONG_IMM), .HAS_ADJ(1'b1), .OPEN_DRAIN(1'b1),
    .RECOVERY_CYC(CNT_W'(REC)), .PULSE_CYC(CNT_W'(PUL)), .SETUP_CYC(CNT_W'(SET))
  ) dut (
    .mclk_in                     (mclk_in),
    .arst_n_in                   (arst_n_in),
    .vcc_under_in                (vcc_under),
    .adjustable_monitor_under_in (adj_under),
    .long_press_input_a_n_in     (btn_a_n),
    .second_press_input_n_in     (btn_b_n),
    .rst_n_out                   (rst_n_out),
    .rst_oe_out                  (rst_oe_out)
  );

  proc_partner partner (
    .rst_n_in     (rst_n_out),
    .rst_oe_in    (rst_oe_out),
    .press_a_in   (press_a),
    .press_b_in   (press_b),
    .rst_line_out (rst_line),
    .btn_a_n_out  (btn_a_n),
    .btn_b_n_out  (btn_b_n)
  );

  // second block: two long press inputs, push-pull, no adjustable monitor
  supervisor_reset_timing #(
    .VARIANT(VAR_DUAL_LONG), .HAS_ADJ(1'b0), .OPEN_DRAIN(1'b0),
    .RECOVERY_CYC(CNT_W'(REC)), .PULSE_CYC(CNT_W'(PUL)), .SETUP_CYC(CNT_W'(SET))
  ) dut_dual (
    .mclk_in                     (mclk_in),
    .arst_n_in                   (arst_n_in),
    .vcc_under_in                (vcc_under),
    .adjustable_monitor_under_in (adj_under),
    .long_press_input_a_n_in     (btn_a_n),
    .second_press_input_n_in     (btn_b_n),
    .rst_n_out                   (rst_n_dual),
    .rst_oe_out                  (rst_oe_dual)
  );

  proc_partner partner_dual (
    .rst_n_in     (rst_n_dual),
    .rst_oe_in    (rst_oe_dual),
    .press_a_in   (press_a),
    .press_b_in   (press_b),
    .rst_line_out (line_dual),
    .btn_a_n_out  (),
    .btn_b_n_out  ()
  );

  // compare seen against expected, allowing tol cycles above it
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] lo,
                       input logic [31:0] tol);
    n_checks++;
    if ((tol == 0) ? (seen !== lo) : (seen < lo || seen > lo + tol)) begin
      err_count++;
      $display("BAD %s expected %0d seen %0d", what, lo, seen);
    end
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // step n edges, then drive a little later
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk_in);
      #5;
    end
  endtask

  // wait for the line to go high, bounded
  task automatic settle();
    int k = 0;
    while (rst_line !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    tick(4);
  endtask

  // monitor: time each low period and match it with the oldest note
  always @(posedge mclk_in) begin
    if (arst_n_in && rst_line === 1'b0) begin
      if (armed)
        width++;
      else if (prev_line === 1'b1) begin
        armed = 1'b1;
        width = 1;
      end
    end else if (armed && rst_line === 1'b1) begin
      armed = 1'b0;
      if (exp_q.size() == 0)
        check("unexpected reset width", width, 0, 0);
      else begin
        e = exp_q.pop_front();
        check("reset width", width, e.lo, e.tol);
      end
    end
    prev_line = rst_line;
    if (arst_n_in)
      check("drive enable", rst_oe_out, !rst_n_out, 0);
  end

  // monitor for the dual variant, same scheme with its own notes
  always @(posedge mclk_in) begin
    if (arst_n_in && line_dual === 1'b0) begin
      if (armed_dual)
        width_dual++;
      else if (prev_dual === 1'b1) begin
        armed_dual = 1'b1;
        width_dual = 1;
      end
    end else if (armed_dual && line_dual === 1'b1) begin
      armed_dual = 1'b0;
      if (dual_q.size() == 0)
        check("unexpected dual width", width_dual, 0, 0);
      else begin
        e_dual = dual_q.pop_front();
        check("dual reset width", width_dual, e_dual.lo, e_dual.tol);
      end
    end
    prev_dual = line_dual;
    if (arst_n_in)
      check("dual drive enable", rst_oe_dual, 1, 0);
  end

  // hang guard
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("BAD timeout expected end seen hang");
      complete_run();
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h3c0c));
    tick(6);
    arst_n_in = 1'b1;
    settle();
    // supply faults, the last on the adjustable monitor
    for (int i = 0; i < 4; i++) begin
      len = 1 + $urandom % 20;
      exp_q.push_back('{len + REC, 0});
      if (i == 3)
        adj_under = 1'b1;
      else begin
        vcc_under = 1'b1;
        dual_q.push_back('{len + REC, 0});
      end
      tick(len);
      vcc_under = 1'b0;
      adj_under = 1'b0;
      settle();
    end
    $display("supply fault test done");
    // short presses give nothing
    for (int i = 0; i < 2; i++) begin
      len = (i == 0) ? 5 + $urandom % (SET - 10) : SET - 2;
      press_a = 1'b1;
      tick(len);
      press_a = 1'b0;
      settle();
    end
    $display("short press test done");
    // long press held well past setup: one pulse only
    exp_q.push_back('{PUL, 0});
    press_a = 1'b1;
    tick(2 * SET + 10);
    press_a = 1'b0;
    settle();
    $display("long press test done");
    // immediate input: glitch ignored, real press resets
    press_b = 1'b1;
    tick(1);
    press_b = 1'b0;
    settle();
    len = 2 + $urandom % 9;
    exp_q.push_back('{len + REC - 1, 2});
    press_b = 1'b1;
    tick(len);
    press_b = 1'b0;
    settle();
    $display("immediate input test done");
    // both buttons held: immediate reset on one block, one pulse on the dual block
    exp_q.push_back('{2 * SET + 10 + REC - 1, 2});
    dual_q.push_back('{PUL, 0});
    press_a = 1'b1;
    press_b = 1'b1;
    tick(2 * SET + 10);
    press_a = 1'b0;
    press_b = 1'b0;
    settle();
    $display("dual press test done");
    tick(20);
    check("pending notes", exp_q.size(), 0, 0);
    check("pending dual notes", dual_q.size(), 0, 0);
    complete_run();
  end
endmodule
